//--- hw/gate_input_select.sv
`timescale 1ns/100ps
`default_nettype none
module gate_input_select (
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [gate_sel_pkg::ADDR_W-1:0] I_AWADDR,
  input wire logic [2:0] I_AWPROT,
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [gate_sel_pkg::ADDR_W-1:0] I_ARADDR,
  input wire logic [2:0] I_ARPROT,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  input wire logic [gate_sel_pkg::SRC_N-1:0] I_SOURCES,
  output logic [gate_sel_pkg::NUM_GATES-1:0] O_GATE_OUT
);

  logic [gate_sel_pkg::SEL_W-1:0] gate_select [gate_sel_pkg::NUM_GATES];
  logic [gate_sel_pkg::NUM_GATES-1:0] gate_invert;
  logic [gate_sel_pkg::SRC_W-1:0] source_select [gate_sel_pkg::NUM_DATA];
  gate_sel_pkg::gate_cfg_t gate_cfg [gate_sel_pkg::NUM_GATES];
  logic [gate_sel_pkg::NUM_DATA-1:0] data_true;
  logic [gate_sel_pkg::NUM_GATES-1:0] gate_out;

  // write side holding registers
  logic aw_held;
  logic w_held;
  logic [gate_sel_pkg::ADDR_W-1:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane0;
  logic bvalid;
  logic [1:0] bresp;

  // read side
  logic rvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;

  wire aw_take = I_AWVALID & O_AWREADY;
  wire w_take = I_WVALID & O_WREADY;
  wire ar_take = I_ARVALID & O_ARREADY;
  wire do_write = aw_held & w_held & ~bvalid;
  wire gate_sel_pkg::reg_id_t wr_id = gate_sel_pkg::decode_addr(aw_addr);
  wire gate_sel_pkg::reg_id_t rd_id = gate_sel_pkg::decode_addr(I_ARADDR);
  // byte lane 0 carries every implemented bit
  wire wr_commit = do_write & w_lane0;
  wire wr_mapped = (wr_id != gate_sel_pkg::REG_NONE);
  wire rd_mapped = (rd_id != gate_sel_pkg::REG_NONE);

  assign O_AWREADY = ~aw_held & ~bvalid;
  assign O_WREADY = ~w_held & ~bvalid;
  assign O_ARREADY = ~rvalid;
  assign O_BVALID = bvalid;
  assign O_BRESP = bresp;
  assign O_RVALID = rvalid;
  assign O_RDATA = rdata;
  assign O_RRESP = rresp;
  assign O_GATE_OUT = gate_out;

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (aw_take) begin
      aw_held <= 1'b1;
      aw_addr <= I_AWADDR;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      w_held <= 1'b0;
      w_byte <= '0;
      w_lane0 <= 1'b0;
    end else if (w_take) begin
      w_held <= 1'b1;
      w_byte <= I_WDATA[7:0];
      w_lane0 <= I_WSTRB[0];
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      bvalid <= 1'b0;
      bresp <= gate_sel_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= wr_mapped ? gate_sel_pkg::RESP_OKAY : gate_sel_pkg::RESP_SLVERR;
    end else if (I_BREADY) begin
      bvalid <= 1'b0;
    end
  end

  // power-on style reset gives the selects a known zero instead of unknown
  genvar g;
  generate
    for (g = 0; g < gate_sel_pkg::NUM_GATES; g++) begin : g_gate
      wire sel_hit = wr_commit &
        (wr_id == gate_sel_pkg::reg_id_t'(int'(gate_sel_pkg::REG_GATE1) + g));
      always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
          gate_select[g] <= gate_sel_pkg::SEL_RESET;
        end else if (sel_hit) begin
          gate_select[g] <= w_byte;
        end
      end
      assign gate_cfg[g].select = gate_select[g];
      assign gate_cfg[g].invert = gate_invert[g];
      gate_or_stage #(
        .NUM_DATA(gate_sel_pkg::NUM_DATA)
      ) u_gate (
        .i_data_true(data_true),
        .i_select(gate_cfg[g].select),
        .i_invert(gate_cfg[g].invert),
        .o_gate(gate_out[g])
      );
    end
    for (g = 0; g < gate_sel_pkg::NUM_DATA; g++) begin : g_data
      wire src_hit = wr_commit &
        (wr_id == gate_sel_pkg::reg_id_t'(int'(gate_sel_pkg::REG_SRC1) + g));
      always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
          source_select[g] <= gate_sel_pkg::SRC_RESET;
        end else if (src_hit) begin
          source_select[g] <= w_byte[gate_sel_pkg::SRC_W-1:0];
        end
      end
      // inverted form is made inside each gate stage
      assign data_true[g] = I_SOURCES[source_select[g]];
    end
  endgenerate

  wire pol_hit = wr_commit & (wr_id == gate_sel_pkg::REG_POL);

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      gate_invert <= gate_sel_pkg::POL_RESET;
    end else if (pol_hit) begin
      gate_invert <= w_byte[gate_sel_pkg::NUM_GATES-1:0];
    end
  end

  // status samples live gate and data levels at the read handshake
  wire [7:0] status_byte = 8'(
    (32'(data_true) << gate_sel_pkg::STATUS_DATA_LSB) |
    (32'(gate_out) << gate_sel_pkg::STATUS_GATE_LSB));

  logic [7:0] read_byte;
  always_comb begin
    read_byte = 8'h00;
    unique case (rd_id)
      gate_sel_pkg::REG_GATE1: read_byte = gate_select[0];
      gate_sel_pkg::REG_GATE2: read_byte = gate_select[1];
      gate_sel_pkg::REG_GATE3: read_byte = gate_select[2];
      gate_sel_pkg::REG_POL: read_byte = {5'h00, gate_invert};
      gate_sel_pkg::REG_SRC1: read_byte = {3'h0, source_select[0]};
      gate_sel_pkg::REG_SRC2: read_byte = {3'h0, source_select[1]};
      gate_sel_pkg::REG_SRC3: read_byte = {3'h0, source_select[2]};
      gate_sel_pkg::REG_SRC4: read_byte = {3'h0, source_select[3]};
      gate_sel_pkg::REG_STATUS: read_byte = status_byte;
      gate_sel_pkg::REG_NONE: read_byte = 8'h00;
    endcase
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= gate_sel_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, read_byte};
      rresp <= rd_mapped ? gate_sel_pkg::RESP_OKAY : gate_sel_pkg::RESP_SLVERR;
    end else if (I_RREADY) begin
      rvalid <= 1'b0;
    end
  end

  // protection bits carry no meaning for this block
  wire unused_prot = ^{I_AWPROT, I_ARPROT, I_WDATA[31:8], I_WSTRB[3:1]};

endmodule
`default_nettype wire

//--- hw/gate_or_stage.sv
`timescale 1ns/100ps
`default_nettype none
module gate_or_stage #(
  parameter int NUM_DATA = 4
) (
  input wire logic [NUM_DATA-1:0] i_data_true,
  input wire logic [2*NUM_DATA-1:0] i_select,
  input wire logic i_invert,
  output logic o_gate
);

  wire [2*NUM_DATA-1:0] candidates;
  wire raw_gate;

  genvar k;
  generate
    for (k = 0; k < NUM_DATA; k++) begin : g_pair
      assign candidates[2*k+1] = i_data_true[k];
      assign candidates[2*k] = ~i_data_true[k];
    end
  endgenerate

  // empty selection ORs to zero
  assign raw_gate = |(i_select & candidates);
  assign o_gate = raw_gate ^ i_invert;

endmodule
`default_nettype wire

//--- hw/gate_sel_pkg.sv
// Operation
// - gate 1 takes true data 4,3,2,1 under select bits 7,5,3,1.
// - gate 1 takes inverted data 4,3,2,1 under select bits 6,4,2,0.
// - gate 2 takes true data 4,3,2,1 under its select bits 7,5,3,1.
// - gate 2 takes inverted data 4,3,2,1 under its select bits 6,4,2,0.
// - gate 3 takes true data 4,3,2,1 under its select bits 7,5,3,1.
// - gate 3 takes inverted data 4,3,2,1 under its select bits 6,4,2,0.
// - a select bit at one includes its data signal in the gate.
// - a select bit at zero excludes its data signal from the gate.
// - select bits are software read/write; only power-on reset defines them.
// - each data input comes from a 5-bit selected source mux, true and inverted.
// - per-gate polarity bit at one inverts the gate output, zero passes it.
package gate_sel_pkg;

  localparam int NUM_GATES = 3;
  localparam int NUM_DATA = 4;
  localparam int SEL_W = 8;
  localparam int SRC_W = 5;
  localparam int SRC_N = 32;
  localparam int ADDR_W = 8;

  localparam logic [ADDR_W-1:0] GATE1_SEL_OFF = 8'h00;
  localparam logic [ADDR_W-1:0] GATE2_SEL_OFF = 8'h04;
  localparam logic [ADDR_W-1:0] GATE3_SEL_OFF = 8'h08;
  localparam logic [ADDR_W-1:0] POLARITY_OFF = 8'h0c;
  localparam logic [ADDR_W-1:0] SRC1_SEL_OFF = 8'h10;
  localparam logic [ADDR_W-1:0] SRC2_SEL_OFF = 8'h14;
  localparam logic [ADDR_W-1:0] SRC3_SEL_OFF = 8'h18;
  localparam logic [ADDR_W-1:0] SRC4_SEL_OFF = 8'h1c;
  localparam logic [ADDR_W-1:0] STATUS_OFF = 8'h20;

  localparam logic [SEL_W-1:0] SEL_RESET = 8'h00;
  localparam logic [NUM_GATES-1:0] POL_RESET = 3'h0;
  localparam logic [SRC_W-1:0] SRC_RESET = 5'h00;

  localparam int STATUS_GATE_LSB = 0;
  localparam int STATUS_DATA_LSB = 4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    REG_GATE1, REG_GATE2, REG_GATE3, REG_POL,
    REG_SRC1, REG_SRC2, REG_SRC3, REG_SRC4, REG_STATUS, REG_NONE
  } reg_id_t;

  typedef struct packed {
    logic [SEL_W-1:0] select;
    logic invert;
  } gate_cfg_t;

  function automatic reg_id_t decode_addr(input logic [ADDR_W-1:0] addr);
    reg_id_t id;
    id = REG_NONE;
    unique case (addr)
      GATE1_SEL_OFF: id = REG_GATE1;
      GATE2_SEL_OFF: id = REG_GATE2;
      GATE3_SEL_OFF: id = REG_GATE3;
      POLARITY_OFF: id = REG_POL;
      SRC1_SEL_OFF: id = REG_SRC1;
      SRC2_SEL_OFF: id = REG_SRC2;
      SRC3_SEL_OFF: id = REG_SRC3;
      SRC4_SEL_OFF: id = REG_SRC4;
      STATUS_OFF: id = REG_STATUS;
      default: id = REG_NONE;
    endcase
    return id;
  endfunction

endpackage

//--- testbench/gate_input_select_checker.sv
`timescale 1ns/100ps
`default_nettype none
module gate_input_select_checker (
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic I_AWVALID,
  input wire logic O_AWREADY,
  input wire logic I_WVALID,
  input wire logic O_WREADY,
  input wire logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic I_ARVALID,
  input wire logic O_ARREADY,
  input wire logic [7:0] I_ARADDR,
  input wire logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic [1:0] O_RRESP,
  input wire logic [2:0] O_GATE_OUT
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  property p_b_hold; O_BVALID && !I_BREADY |=> O_BVALID; endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  property p_r_hold; O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data unstable");
  property p_w_resp; I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |=> !O_BVALID ##1 O_BVALID;
  endproperty
  a_w_resp: assert property (p_w_resp) else $error("write answer late");
  property p_r_resp; I_ARVALID && O_ARREADY |=> O_RVALID; endproperty
  a_r_resp: assert property (p_r_resp) else $error("read answer late");
  property p_ar_block; O_RVALID |-> !O_ARREADY; endproperty
  a_ar_block: assert property (p_ar_block) else $error("second read taken");
  property p_b_block; O_BVALID |-> !O_AWREADY && !O_WREADY; endproperty
  a_b_block: assert property (p_b_block) else $error("second write taken");
  // unaligned or past the last register must be refused
  property p_unmapped; I_ARVALID && O_ARREADY && (I_ARADDR > 8'h20 || I_ARADDR[1:0] != 2'h0)
    |=> O_RRESP == 2'h2 && O_RDATA == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read accepted");
  property p_rst_zero; $fell(I_RST) |-> O_GATE_OUT == 3'h0; endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("gates active after reset");
  cover property (O_RVALID && O_RRESP == 2'h2);
  cover property (O_GATE_OUT == 3'h7);
  cover property (O_BVALID);
endmodule
bind gate_input_select gate_input_select_checker chk_u (.I_CLOCK, .I_RST, .I_AWVALID,
  .O_AWREADY, .I_WVALID, .O_WREADY, .O_BVALID, .I_BREADY, .I_ARVALID, .O_ARREADY,
  .I_ARADDR, .O_RVALID, .I_RREADY, .O_RDATA, .O_RRESP, .O_GATE_OUT);
`default_nettype wire

//--- testbench/gate_input_select_tb.sv
`timescale 1ns/100ps
`default_nettype none
module gate_input_select_tb;
  logic I_CLOCK = 0, I_RST = 1, I_AWVALID = 0, I_WVALID = 0, I_BREADY = 0;
  logic I_ARVALID = 0, I_RREADY = 0, O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
  logic [7:0] I_AWADDR = 0, I_ARADDR = 0, v8;
  logic [31:0] I_WDATA = 0, O_RDATA, I_SOURCES = 0, seed = 32'hf3971f62, d, v;
  logic [3:0] I_WSTRB = 0;
  logic [1:0] O_BRESP, O_RRESP, r;
  logic [2:0] O_GATE_OUT, pol;
  logic [7:0] sel [3];
  logic [4:0] src [4];
  int num_errors = 0, checks_done = 0;
  gate_input_select dut_u (.I_CLOCK, .I_RST, .I_AWVALID, .O_AWREADY, .I_AWADDR,
    .I_AWPROT(3'h0), .I_WVALID, .O_WREADY, .I_WDATA, .I_WSTRB, .O_BVALID, .I_BREADY,
    .O_BRESP, .I_ARVALID, .O_ARREADY, .I_ARADDR, .I_ARPROT(3'h0), .O_RVALID, .I_RREADY,
    .O_RDATA, .O_RRESP, .I_SOURCES, .O_GATE_OUT);
  always #50 I_CLOCK = ~I_CLOCK;
  function automatic logic [31:0] nx(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [2:0] model(input logic [31:0] s);
    logic [2:0] o;
    o = 3'h0;
    for (int g = 0; g < 3; g++) begin
      for (int k = 0; k < 4; k++) begin
        o[g] |= sel[g][2*k+1] & s[src[k]] | sel[g][2*k] & ~s[src[k]];
      end
    end
    return o ^ pol;
  endfunction
  // read-back value of register n: selects, polarity, sources, then live status
  function automatic logic [31:0] expect_reg(input int n, input logic [31:0] s);
    logic [3:0] dl;
    for (int k = 0; k < 4; k++) begin
      dl[k] = s[src[k]];
    end
    case (n)
      0, 1, 2: return 32'(sel[n]);
      3: return 32'(pol);
      8: return 32'({dl, 1'b0, model(s)});
      default: return 32'(src[n-4]);
    endcase
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one task for both directions; the leading edge keeps a release and the next raise apart
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] x,
                     input logic [3:0] s, output logic [31:0] q, output logic [1:0] rr);
    logic ka, kw, kr, ok;
    ok = 0;
    @(posedge I_CLOCK);
    I_AWVALID <= w;
    I_WVALID <= w;
    I_ARVALID <= !w;
    I_AWADDR <= a;
    I_ARADDR <= a;
    I_WDATA <= x;
    I_WSTRB <= s;
    I_BREADY <= w;
    I_RREADY <= !w;
    repeat (40) if (!ok) begin
      @(negedge I_CLOCK);
      ka = O_AWREADY;
      kw = O_WREADY;
      kr = O_ARREADY;
      ok = w ? O_BVALID : O_RVALID;
      q = O_RDATA;
      rr = w ? O_BRESP : O_RRESP;
      @(posedge I_CLOCK);
      if (ka) I_AWVALID <= 0;
      if (kw) I_WVALID <= 0;
      if (kr) I_ARVALID <= 0;
      if (ok) I_BREADY <= 0;
      if (ok) I_RREADY <= 0;
    end
    if (!ok) begin
      num_errors++;
      stop_test;
    end
  endtask
  initial begin
    repeat (12) @(posedge I_CLOCK);
    I_RST <= 0;
    for (int i = 0; i < 40; i++) begin
      // first eight passes walk a single select bit, the ninth sets none at all
      for (int n = 0; n < 8; n++) begin
        seed = nx(seed);
        v = seed;
        if (i < 9 && n < 3) v[7:0] = 8'h01 << i;
        v8 = gate_sel_pkg::GATE1_SEL_OFF + 8'(4 * n);
        bus(1'b1, v8, v, 4'hf, d, r);
        chk(32'(r), 32'h0);
        if (n < 3) sel[n] = v[7:0];
        else if (n == 3) pol = v[2:0];
        else src[n-4] = v[4:0];
      end
      repeat (4) begin
        seed = nx(seed);
        I_SOURCES <= seed;
        @(negedge I_CLOCK);
        chk(32'(O_GATE_OUT), 32'(model(seed)));
        @(posedge I_CLOCK);
      end
      // every register, status included, is read back in turn
      v8 = gate_sel_pkg::GATE1_SEL_OFF + 8'(4 * (i % 9));
      bus(1'b0, v8, 32'h0, 4'h0, d, r);
      chk(d, expect_reg(i % 9, seed));
      chk(32'(r), 32'h0);
    end
    bus(1'b1, gate_sel_pkg::GATE1_SEL_OFF, ~32'(sel[0]), 4'h0, d, r);
    bus(1'b0, gate_sel_pkg::GATE1_SEL_OFF, 32'h0, 4'h0, d, r);
    chk(d, 32'(sel[0]));
    bus(1'b1, 8'h24, 32'hff, 4'hf, d, r);
    chk(32'(r), 32'h2);
    bus(1'b0, 8'h24, 32'h0, 4'h0, d, r);
    chk({d[29:0], r}, 32'h2);
    stop_test;
  end
endmodule
`default_nettype wire
